// ### design/config_fuse_bank.sv
// Configuration fuse bank: stored option bytes, their byte port, the
// decoded device-wide controls and the memory protection verdicts.
// Assumes a synchronous byte-wide register port on clk_sys_i and a reset
// pin and stack fault signals arriving from outside or from the core.
//
// The implementer's own choice: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none

module config_fuse_bank #(
  parameter bit HAS_BLOCK3 = 1'b1,
  parameter bit HAS_DEBUG_PORT = 1'b1,
  parameter bit BIG_BOOT = 1'b0
) (
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  input wire logic [23:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_write_i,
  input wire logic reg_read_i,
  output logic [7:0] reg_rdata_o,
  input wire logic program_mode_i,
  input wire logic sw_watchdog_on_i,
  input wire logic shared_pin_i,
  output logic ext_reset_n_o,
  output logic port_e_pin_three_o,
  input wire logic stack_fault_i,
  output logic stack_reset_o,
  input wire logic lvp_entry_req_i,
  output logic lvp_entry_ok_o,
  input wire logic capcmp_unit_two_out_i,
  output logic port_c_pin_one_o,
  output logic port_b_pin_three_o,
  output logic port_b_debug_pins_o,
  output logic [7:0] analog_config_reset_o,
  output cfg_fuse_pkg::ctrl_s ctrl_o,
  input wire logic [23:0] access_addr_i,
  input wire logic [23:0] exec_addr_i,
  input wire logic access_external_i,
  input wire logic access_table_read_i,
  input wire logic access_eeprom_i,
  output logic access_read_ok_o,
  output logic access_write_ok_o
);

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  typedef struct packed {
    cfg_fuse_pkg::fuse_s fuse;
    cfg_fuse_pkg::ctrl_s ctrl;
    logic [7:0] rdata;
    logic [1:0] pin_sync;
    logic latched;
  } state_s;

  localparam logic [7:0] ANALOG_ALL = 8'h00;
  localparam logic [7:0] ANALOG_NONE = 8'h07;

  state_s state;
  state_s next_state;

  // Block 3 guard bits are tied high on parts without the block.
  localparam logic [7:0] BLK_FIXED = HAS_BLOCK3 ? 8'h00 : (8'h01 << cfg_fuse_pkg::BLK3_BIT);

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  // Programmable byte: program mode stores freely, masked to live bits.
  function automatic logic [7:0] prog_byte(input logic [7:0] mask, input logic [7:0] wd);
    prog_byte = wd & mask;
  endfunction : prog_byte

  // Clear-only byte: ordinary writes can only drive bits to zero, and the
  // programmer in program mode may also restore them.
  function automatic logic [7:0] clr_byte(input logic [7:0] cur, input logic [7:0] wd,
                                          input logic [7:0] mask, input logic pm,
                                          input logic [7:0] fixed);
    logic [7:0] v;
    v = pm ? wd : (cur & wd);
    clr_byte = (v | fixed) & mask;
  endfunction : clr_byte

  logic [7:0] dbg_mask;

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  // Writes land in the fuse bytes only; the decoded controls change only
  // on reset so software cannot alter them mid-run; protection verdicts follow the live fuse bytes.
  always_comb begin
    next_state = state;
    dbg_mask = cfg_fuse_pkg::MASK_DEBUG_CORE;
    if (!HAS_DEBUG_PORT)
      dbg_mask[cfg_fuse_pkg::DBG_PORT_BIT] = 1'b0;
    next_state.pin_sync = {state.pin_sync[0], shared_pin_i};
    next_state.rdata = 8'h00;
    if (reg_read_i) begin
      unique case (reg_addr_i)
        cfg_fuse_pkg::ADDR_WATCHDOG: next_state.rdata = state.fuse.watchdog;
        cfg_fuse_pkg::ADDR_PIN_FUNC: next_state.rdata = state.fuse.pin_func;
        cfg_fuse_pkg::ADDR_DEBUG_CORE: next_state.rdata = state.fuse.debug_core;
        cfg_fuse_pkg::ADDR_CP_LOW: next_state.rdata = state.fuse.cp_low;
        cfg_fuse_pkg::ADDR_CP_HIGH: next_state.rdata = state.fuse.cp_high;
        cfg_fuse_pkg::ADDR_WP_LOW: next_state.rdata = state.fuse.wp_low;
        cfg_fuse_pkg::ADDR_WP_HIGH: next_state.rdata = state.fuse.wp_high;
        cfg_fuse_pkg::ADDR_TR_LOW: next_state.rdata = state.fuse.tr_low;
        default: next_state.rdata = 8'h00;
      endcase
    end
    // Protection bytes change in program mode or while the configuration
    // area is not write-locked; the other option bytes only in program mode.
    if (reg_write_i && (program_mode_i || state.fuse.wp_high[cfg_fuse_pkg::CFG_WP_BIT])) begin
      unique case (reg_addr_i)
        cfg_fuse_pkg::ADDR_WATCHDOG:
          if (program_mode_i) next_state.fuse.watchdog = prog_byte(cfg_fuse_pkg::MASK_WATCHDOG, reg_wdata_i);
        cfg_fuse_pkg::ADDR_PIN_FUNC:
          if (program_mode_i) next_state.fuse.pin_func = prog_byte(cfg_fuse_pkg::MASK_PIN_FUNC, reg_wdata_i);
        cfg_fuse_pkg::ADDR_DEBUG_CORE:
          if (program_mode_i) next_state.fuse.debug_core = prog_byte(dbg_mask, reg_wdata_i);
        cfg_fuse_pkg::ADDR_CP_LOW:
          next_state.fuse.cp_low = clr_byte(state.fuse.cp_low, reg_wdata_i,
                                            cfg_fuse_pkg::MASK_BLOCKS, program_mode_i, BLK_FIXED);
        cfg_fuse_pkg::ADDR_CP_HIGH:
          next_state.fuse.cp_high = clr_byte(state.fuse.cp_high, reg_wdata_i,
                                             cfg_fuse_pkg::MASK_CP_HIGH, program_mode_i, 8'h00);
        cfg_fuse_pkg::ADDR_WP_LOW:
          next_state.fuse.wp_low = clr_byte(state.fuse.wp_low, reg_wdata_i,
                                            cfg_fuse_pkg::MASK_BLOCKS, program_mode_i, BLK_FIXED);
        cfg_fuse_pkg::ADDR_WP_HIGH: begin
          next_state.fuse.wp_high = clr_byte(state.fuse.wp_high, reg_wdata_i,
                                             cfg_fuse_pkg::MASK_WP_HIGH, program_mode_i, 8'h00);
          // The config lock bit is read-only outside program mode.
          if (!program_mode_i)
            next_state.fuse.wp_high[cfg_fuse_pkg::CFG_WP_BIT] = state.fuse.wp_high[cfg_fuse_pkg::CFG_WP_BIT];
        end
        cfg_fuse_pkg::ADDR_TR_LOW:
          next_state.fuse.tr_low = clr_byte(state.fuse.tr_low, reg_wdata_i,
                                            cfg_fuse_pkg::MASK_BLOCKS, program_mode_i, BLK_FIXED);
        default: ;
      endcase
    end
    // One cycle after reset release the controls are decoded once and then
    // frozen, so the sampled bytes are always the stored ones.
    if (!state.latched) begin
      next_state.latched = 1'b1;
      next_state.ctrl.watchdog_divide = 16'h0001 << state.fuse.watchdog[cfg_fuse_pkg::WD_PS_LSB +: cfg_fuse_pkg::WD_PS_W];
      next_state.ctrl.watchdog_run = state.fuse.watchdog[cfg_fuse_pkg::WD_ON_BIT];
      next_state.ctrl.reset_pin_select = state.fuse.pin_func[cfg_fuse_pkg::RST_PIN_BIT];
      next_state.ctrl.low_power_timer_osc = state.fuse.pin_func[cfg_fuse_pkg::LP_OSC_BIT];
      next_state.ctrl.port_b_analog_at_reset = state.fuse.pin_func[cfg_fuse_pkg::PB_AN_BIT];
      next_state.ctrl.capcmp2_pin_select = state.fuse.pin_func[cfg_fuse_pkg::CCP_MUX_BIT];
      next_state.ctrl.debug_enabled = !state.fuse.debug_core[cfg_fuse_pkg::DBG_OFF_BIT];
      next_state.ctrl.extended_isa_on = state.fuse.debug_core[cfg_fuse_pkg::XISA_BIT];
      next_state.ctrl.dedicated_debug_port = state.fuse.debug_core[cfg_fuse_pkg::DBG_PORT_BIT];
      next_state.ctrl.single_supply_prog_on = state.fuse.debug_core[cfg_fuse_pkg::LVP_ON_BIT];
      next_state.ctrl.stack_fault_reset_on = state.fuse.debug_core[cfg_fuse_pkg::STK_RST_BIT];
    end
  end

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  // The fuse bytes survive reset, as non-volatile storage would; only a
  // power-up style load happens at first use via the blank values below.
  // Starts low, as on a blank part, so only the first reset loads blanks.
  logic fuse_loaded = 1'b0;

  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      state.ctrl <= '0;
      state.rdata <= 8'h00;
      state.pin_sync <= 2'b11;
      state.latched <= 1'b0;
      if (!fuse_loaded) begin
        state.fuse.watchdog <= cfg_fuse_pkg::BLANK_WATCHDOG;
        state.fuse.pin_func <= cfg_fuse_pkg::BLANK_PIN_FUNC;
        state.fuse.debug_core <= cfg_fuse_pkg::BLANK_DEBUG_CORE;
        state.fuse.cp_low <= cfg_fuse_pkg::BLANK_BLOCKS;
        state.fuse.cp_high <= cfg_fuse_pkg::BLANK_CP_HIGH;
        state.fuse.wp_low <= cfg_fuse_pkg::BLANK_BLOCKS;
        state.fuse.wp_high <= cfg_fuse_pkg::BLANK_WP_HIGH;
        state.fuse.tr_low <= cfg_fuse_pkg::BLANK_BLOCKS;
      end
      fuse_loaded <= 1'b1;
    end else begin
      state <= next_state;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign reg_rdata_o = state.rdata;
  assign ctrl_o = state.ctrl;
  // Software enable only counts while the hardware enable is clear.
  logic wd_active;
  assign wd_active = state.ctrl.watchdog_run || sw_watchdog_on_i;
  // Shared pin: reset or plain input, never both.
  assign ext_reset_n_o = state.ctrl.reset_pin_select ? state.pin_sync[1] : 1'b1;
  assign port_e_pin_three_o = state.ctrl.reset_pin_select ? 1'b0 : state.pin_sync[1];
  assign stack_reset_o = stack_fault_i && state.ctrl.stack_fault_reset_on;
  assign lvp_entry_ok_o = lvp_entry_req_i && state.ctrl.single_supply_prog_on;
  assign port_c_pin_one_o = state.ctrl.capcmp2_pin_select && capcmp_unit_two_out_i;
  assign port_b_pin_three_o = !state.ctrl.capcmp2_pin_select && capcmp_unit_two_out_i;
  assign port_b_debug_pins_o = state.ctrl.debug_enabled;
  assign analog_config_reset_o = state.ctrl.port_b_analog_at_reset ? ANALOG_ALL : ANALOG_NONE;

  // Memory access verdicts.
  fuse_guard #(
    .BIG_BOOT(BIG_BOOT)
  ) u_guard (
    .cp_low_i(state.fuse.cp_low),
    .cp_high_i(state.fuse.cp_high),
    .wp_low_i(state.fuse.wp_low),
    .wp_high_i(state.fuse.wp_high),
    .tr_low_i(state.fuse.tr_low),
    .access_addr_i(access_addr_i),
    .exec_addr_i(exec_addr_i),
    .external_i(access_external_i),
    .table_read_i(access_table_read_i),
    .eeprom_i(access_eeprom_i),
    .program_mode_i(program_mode_i),
    .read_ok_o(access_read_ok_o),
    .write_ok_o(access_write_ok_o)
  );

endmodule : config_fuse_bank
`default_nettype wire

// ### design/fuse_guard.sv
// Protection checker: decides whether a memory access is allowed.
// Assumes fuse bytes from the bank and a requester on the same clock.
`timescale 1ns/1ps
`default_nettype none

module fuse_guard #(
  parameter bit BIG_BOOT = 1'b0
) (
  input wire logic [7:0] cp_low_i,
  input wire logic [7:0] cp_high_i,
  input wire logic [7:0] wp_low_i,
  input wire logic [7:0] wp_high_i,
  input wire logic [7:0] tr_low_i,
  input wire logic [23:0] access_addr_i,
  input wire logic [23:0] exec_addr_i,
  input wire logic external_i,
  input wire logic table_read_i,
  input wire logic eeprom_i,
  input wire logic program_mode_i,
  output logic read_ok_o,
  output logic write_ok_o
);

  // ----------------------------------------------------------------------
  // Region decode
  // ----------------------------------------------------------------------
  // Used for both target and executing address, hence a function.
  function automatic cfg_fuse_pkg::region_e region_of(input logic [23:0] a);
    if (a <= cfg_fuse_pkg::BOOT_END) region_of = cfg_fuse_pkg::RG_BOOT;
    else if (a <= cfg_fuse_pkg::BLK0_END) region_of = cfg_fuse_pkg::RG_B0;
    else if (a <= cfg_fuse_pkg::BLK1_END) region_of = cfg_fuse_pkg::RG_B1;
    else if (a <= cfg_fuse_pkg::BLK2_END) region_of = cfg_fuse_pkg::RG_B2;
    else if (a <= cfg_fuse_pkg::BLK3_END) region_of = cfg_fuse_pkg::RG_B3;
    else region_of = cfg_fuse_pkg::RG_OTHER;
  endfunction : region_of

  cfg_fuse_pkg::region_e tgt;
  cfg_fuse_pkg::region_e src;
  logic in_cfg;
  logic in_big_boot;

  // Combinational verdict; a cleared guard bit denies, a set one allows.
  always_comb begin
    tgt = region_of(access_addr_i);
    src = region_of(exec_addr_i);
    in_cfg = (access_addr_i >= cfg_fuse_pkg::CFG_LO) && (access_addr_i <= cfg_fuse_pkg::CFG_HI);
    in_big_boot = BIG_BOOT && (access_addr_i <= cfg_fuse_pkg::BOOT_END_BIG);
    read_ok_o = 1'b1;
    write_ok_o = 1'b1;
    if (eeprom_i) begin
      read_ok_o = !external_i || cp_high_i[cfg_fuse_pkg::EE_BIT];
      write_ok_o = wp_high_i[cfg_fuse_pkg::EE_BIT];
    end else if (in_cfg) begin
      write_ok_o = program_mode_i || wp_high_i[cfg_fuse_pkg::CFG_WP_BIT];
    end else if (tgt == cfg_fuse_pkg::RG_BOOT) begin
      read_ok_o = !external_i || cp_high_i[cfg_fuse_pkg::BOOT_BIT];
      write_ok_o = wp_high_i[cfg_fuse_pkg::BOOT_BIT];
    end else if (tgt != cfg_fuse_pkg::RG_OTHER) begin
      read_ok_o = !external_i || cp_low_i[tgt - cfg_fuse_pkg::RG_B0];
      // Block 0 may start later when the boot block is enlarged.
      write_ok_o = in_big_boot ? wp_high_i[cfg_fuse_pkg::BOOT_BIT] : wp_low_i[tgt - cfg_fuse_pkg::RG_B0];
      if (table_read_i && !external_i && src != tgt && !tr_low_i[tgt - cfg_fuse_pkg::RG_B0])
        read_ok_o = 1'b0;
    end
  end

endmodule : fuse_guard
`default_nettype wire

// ### inc/cfg_fuse_pkg.sv
// Package for the configuration fuse bank: byte addresses, field positions,
// unprogrammed values and the carrier structs shared by the design files.
// Assumes a byte-wide register port with a 24-bit address.
package cfg_fuse_pkg;

  // ----------------------------------------------------------------------
  // Byte addresses
  // ----------------------------------------------------------------------
  localparam logic [23:0] ADDR_WATCHDOG = 24'h300003;
  localparam logic [23:0] ADDR_PIN_FUNC = 24'h300005;
  localparam logic [23:0] ADDR_DEBUG_CORE = 24'h300006;
  localparam logic [23:0] ADDR_CP_LOW = 24'h300008;
  localparam logic [23:0] ADDR_CP_HIGH = 24'h300009;
  localparam logic [23:0] ADDR_WP_LOW = 24'h30000A;
  localparam logic [23:0] ADDR_WP_HIGH = 24'h30000B;
  localparam logic [23:0] ADDR_TR_LOW = 24'h30000C;

  // ----------------------------------------------------------------------
  // Implemented-bit masks and unprogrammed values
  // ----------------------------------------------------------------------
  localparam logic [7:0] MASK_WATCHDOG = 8'h1F;
  localparam logic [7:0] MASK_PIN_FUNC = 8'h87;
  localparam logic [7:0] MASK_DEBUG_CORE = 8'hE5;
  localparam logic [7:0] MASK_BLOCKS = 8'h0F;
  localparam logic [7:0] MASK_CP_HIGH = 8'hC0;
  localparam logic [7:0] MASK_WP_HIGH = 8'hE0;
  localparam logic [7:0] BLANK_WATCHDOG = 8'h1F;
  localparam logic [7:0] BLANK_PIN_FUNC = 8'h83;
  localparam logic [7:0] BLANK_DEBUG_CORE = 8'h85;
  localparam logic [7:0] BLANK_BLOCKS = 8'h0F;
  localparam logic [7:0] BLANK_CP_HIGH = 8'hC0;
  localparam logic [7:0] BLANK_WP_HIGH = 8'hE0;

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int WD_ON_BIT = 0;
  localparam int WD_PS_LSB = 1;
  localparam int WD_PS_W = 4;
  localparam int RST_PIN_BIT = 7;
  localparam int LP_OSC_BIT = 2;
  localparam int PB_AN_BIT = 1;
  localparam int CCP_MUX_BIT = 0;
  localparam int DBG_OFF_BIT = 7;
  localparam int XISA_BIT = 6;
  localparam int DBG_PORT_BIT = 5;
  localparam int LVP_ON_BIT = 2;
  localparam int STK_RST_BIT = 0;
  localparam int EE_BIT = 7;
  localparam int BOOT_BIT = 6;
  localparam int CFG_WP_BIT = 5;
  localparam int BLK3_BIT = 3;

  // ----------------------------------------------------------------------
  // Memory map for protection decode
  // ----------------------------------------------------------------------
  localparam logic [23:0] BOOT_END = 24'h0007FF;
  localparam logic [23:0] BOOT_END_BIG = 24'h000FFF;
  localparam logic [23:0] BLK0_END = 24'h001FFF;
  localparam logic [23:0] BLK1_END = 24'h003FFF;
  localparam logic [23:0] BLK2_END = 24'h005FFF;
  localparam logic [23:0] BLK3_END = 24'h007FFF;
  localparam logic [23:0] CFG_LO = 24'h300000;
  localparam logic [23:0] CFG_HI = 24'h3000FF;
  localparam logic [2:0] REG_NONE = 3'h7;

  // Memory region that an address falls in.
  typedef enum logic [2:0] {RG_BOOT, RG_B0, RG_B1, RG_B2, RG_B3, RG_OTHER} region_e;

  // Stored fuse bytes.
  typedef struct packed {
    logic [7:0] watchdog;
    logic [7:0] pin_func;
    logic [7:0] debug_core;
    logic [7:0] cp_low;
    logic [7:0] cp_high;
    logic [7:0] wp_low;
    logic [7:0] wp_high;
    logic [7:0] tr_low;
  } fuse_s;

  // Device-wide control outputs decoded from the fuses.
  typedef struct packed {
    logic watchdog_run;
    logic [15:0] watchdog_divide;
    logic reset_pin_select;
    logic low_power_timer_osc;
    logic port_b_analog_at_reset;
    logic capcmp2_pin_select;
    logic debug_enabled;
    logic extended_isa_on;
    logic dedicated_debug_port;
    logic single_supply_prog_on;
    logic stack_fault_reset_on;
  } ctrl_s;

endpackage : cfg_fuse_pkg

// ### sim/fuse_bank_sva.sv
// Checker for the fuse bank: decoded controls, pin steering, read data.
// Assumes binding onto config_fuse_bank; one clock, synchronous reset.
`timescale 1ns/1ps
`default_nettype none
module fuse_bank_sva (
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  input wire logic [23:0] reg_addr_i,
  input wire logic reg_read_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic stack_fault_i,
  input wire logic stack_reset_o,
  input wire logic lvp_entry_req_i,
  input wire logic lvp_entry_ok_o,
  input wire logic capcmp_unit_two_out_i,
  input wire logic port_c_pin_one_o,
  input wire logic port_b_pin_three_o,
  input wire logic ext_reset_n_o,
  input wire logic port_e_pin_three_o,
  input wire logic port_b_debug_pins_o,
  input wire logic [7:0] analog_config_reset_o,
  input wire cfg_fuse_pkg::ctrl_s ctrl_o
);
  // Controls are decoded one edge after release, so checks wait until they settle.
  logic [1:0] up_cnt;
  logic ok;
  assign ok = (up_cnt == 2'h3);
  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) up_cnt <= 2'h0;
    else if (!ok) up_cnt <= up_cnt + 2'h1;
  end
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!reset_n_i);
  a_unmapped_read_zero: assert property ($past(reg_read_i) && $past(reg_addr_i) == 24'h300004
    |-> reg_rdata_o == 8'h00) else $error("unmapped byte read nonzero");
  a_unused_bits_zero: assert property ($past(reg_read_i) && $past(reg_addr_i) == 24'h300005
    |-> reg_rdata_o[6:3] == 4'h0) else $error("unused pin byte bits nonzero");
  a_stack_reset_gate: assert property (ok |-> stack_reset_o == (stack_fault_i && ctrl_o.stack_fault_reset_on))
    else $error("stack reset gating wrong");
  a_lvp_entry_gate: assert property (ok |-> lvp_entry_ok_o == (lvp_entry_req_i && ctrl_o.single_supply_prog_on))
    else $error("single supply entry gating wrong");
  a_capcmp_route_pin: assert property (ok |-> capcmp_unit_two_out_i ==
    (ctrl_o.capcmp2_pin_select ? port_c_pin_one_o : port_b_pin_three_o)
    && !(ctrl_o.capcmp2_pin_select ? port_b_pin_three_o : port_c_pin_one_o)) else $error("capture unit routed wrong");
  a_pin_input_mode: assert property (ok && !ctrl_o.reset_pin_select |-> ext_reset_n_o)
    else $error("reset asserted from input pin");
  a_pin_reset_mode: assert property (ok && ctrl_o.reset_pin_select |-> !port_e_pin_three_o)
    else $error("input function live on reset pin");
  a_analog_reset_default: assert property (ok |-> analog_config_reset_o ==
    (ctrl_o.port_b_analog_at_reset ? 8'h00 : 8'h07)) else $error("analog default wrong");
  a_debug_pin_claim: assert property (ok |-> port_b_debug_pins_o == ctrl_o.debug_enabled)
    else $error("debug pins claim wrong");
  a_divide_one_hot: assert property (ok |-> $onehot(ctrl_o.watchdog_divide))
    else $error("watchdog divide not a power of two");
  a_ctrl_held_static: assert property (ok |-> $stable(ctrl_o))
    else $error("controls changed without reset");
  cover property (ok && stack_fault_i && stack_reset_o);
  cover property (ok && !ctrl_o.reset_pin_select);
  cover property ($past(reg_read_i) && reg_rdata_o != 8'h00);
endmodule : fuse_bank_sva
bind config_fuse_bank fuse_bank_sva u_sva (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i),
  .reg_addr_i(reg_addr_i), .reg_read_i(reg_read_i), .reg_rdata_o(reg_rdata_o),
  .stack_fault_i(stack_fault_i), .stack_reset_o(stack_reset_o), .lvp_entry_req_i(lvp_entry_req_i),
  .lvp_entry_ok_o(lvp_entry_ok_o), .capcmp_unit_two_out_i(capcmp_unit_two_out_i),
  .port_c_pin_one_o(port_c_pin_one_o), .port_b_pin_three_o(port_b_pin_three_o),
  .ext_reset_n_o(ext_reset_n_o), .port_e_pin_three_o(port_e_pin_three_o),
  .port_b_debug_pins_o(port_b_debug_pins_o), .analog_config_reset_o(analog_config_reset_o), .ctrl_o(ctrl_o));
`default_nettype wire

// ### sim/fuse_programmer.sv
// Programmer model: owns the byte port and the program-mode level.
// Assumes the bank takes strobes on the rising edge of clk_sys_i.
`timescale 1ns/1ps
`default_nettype none
module fuse_programmer #(
  parameter bit BIG_PKG = 1'b1
) (
  input wire logic clk_sys_i,
  input wire logic [7:0] rdata_i,
  output logic [23:0] addr_o,
  output logic [7:0] wdata_o,
  output logic write_o,
  output logic read_o,
  output logic prog_o
);
  // Idle bus shows inverted last values, so a stale address never passes for a held one.
  initial begin
    addr_o = 24'h000000;
    wdata_o = 8'h00;
    write_o = 1'b0;
    read_o = 1'b0;
    prog_o = 1'b0;
  end
  task automatic wr(input logic [23:0] a, input logic [7:0] d);
    @(posedge clk_sys_i);
    addr_o <= a;
    wdata_o <= d;
    write_o <= 1'b1;
    @(posedge clk_sys_i);
    write_o <= 1'b0;
    addr_o <= ~a;
    wdata_o <= ~d;
  endtask : wr
  task automatic rd(input logic [23:0] a, output logic [7:0] d);
    @(posedge clk_sys_i);
    addr_o <= a;
    read_o <= 1'b1;
    @(posedge clk_sys_i);
    read_o <= 1'b0;
    addr_o <= ~a;
    #1;
    d = rdata_i;
  endtask : rd
  // Program mode spans one write; small packages never get the debug port bit.
  task automatic burn(input logic [23:0] a, input logic [7:0] d);
    logic [7:0] v;
    v = d;
    if (a == cfg_fuse_pkg::ADDR_DEBUG_CORE && !BIG_PKG) v[5] = 1'b0;
    prog_o <= 1'b1;
    wr(a, v);
    prog_o <= 1'b0;
  endtask : burn
endmodule : fuse_programmer
`default_nettype wire

// ### sim/tb.sv
// Self-checking bench for the fuse bank with a programmer model on its byte port.
// Assumes a 20 MHz clock and synchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clk_sys_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic [23:0] addr, aa = 24'h0, xa = 24'h0;
  logic [7:0] wdata, rdata, acfg;
  logic wr_s, rd_s, prog, pin = 1'b1, sf = 1'b0, lreq = 1'b0, ccp = 1'b0, ext = 1'b0, tbl = 1'b0, ee = 1'b0;
  logic ext_rst_n, pe3, pc1, pb3, dbg, sr, lok, rok, wok;
  cfg_fuse_pkg::ctrl_s ctrl;
  int n_fail = 0, tests_run = 0, cycles = 0;
  always #25 clk_sys_i = ~clk_sys_i;
  fuse_programmer u_prog (.clk_sys_i(clk_sys_i), .rdata_i(rdata), .addr_o(addr), .wdata_o(wdata),
    .write_o(wr_s), .read_o(rd_s), .prog_o(prog));
  config_fuse_bank u_dut (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .reg_addr_i(addr), .reg_wdata_i(wdata),
    .reg_write_i(wr_s), .reg_read_i(rd_s), .reg_rdata_o(rdata), .program_mode_i(prog), .sw_watchdog_on_i(1'b1),
    .shared_pin_i(pin), .ext_reset_n_o(ext_rst_n), .port_e_pin_three_o(pe3), .stack_fault_i(sf),
    .stack_reset_o(sr), .lvp_entry_req_i(lreq), .lvp_entry_ok_o(lok), .capcmp_unit_two_out_i(ccp),
    .port_c_pin_one_o(pc1), .port_b_pin_three_o(pb3), .port_b_debug_pins_o(dbg), .analog_config_reset_o(acfg),
    .ctrl_o(ctrl), .access_addr_i(aa), .exec_addr_i(xa), .access_external_i(ext), .access_table_read_i(tbl),
    .access_eeprom_i(ee), .access_read_ok_o(rok), .access_write_ok_o(wok));
  // ----------------------------------------------------------------------
  // Shared checks
  // ----------------------------------------------------------------------
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic rchk(input logic [23:0] a, input logic [7:0] exp);
    logic [7:0] d;
    u_prog.rd(a, d);
    chk("rdata", {8'h00, d}, {8'h00, exp});
  endtask : rchk
  // Access verdicts are combinational, so they are sampled just after the inputs land.
  task automatic acc(input logic [23:0] a, input logic [23:0] x, input logic [2:0] m, input logic [1:0] e);
    @(posedge clk_sys_i);
    aa <= a;
    xa <= x;
    {ext, tbl, ee} <= m;
    #1;
    chk("access", {14'h0, rok, wok}, {14'h0, e});
  endtask : acc
  task automatic t_blank;
    rchk(24'h300003, 8'h1F);
    rchk(24'h300005, 8'h83);
    rchk(24'h300006, 8'h85);
    rchk(24'h300008, 8'h0F);
    rchk(24'h300009, 8'hC0);
    rchk(24'h30000A, 8'h0F);
    rchk(24'h30000B, 8'hE0);
    rchk(24'h30000C, 8'h0F);
    rchk(24'h300004, 8'h00);
    chk("divide", ctrl.watchdog_divide, 16'h8000);
    chk("wd_run", {15'h0, ctrl.watchdog_run}, 16'h1);
    @(posedge clk_sys_i);
    {sf, lreq, ccp, pin} <= 4'b1110;
    repeat (4) @(posedge clk_sys_i);
    #1;
    chk("blank_pins", {10'h0, sr, lok, pc1, ext_rst_n, pe3, dbg}, 16'h0038);
  endtask : t_blank
  task automatic t_user;
    u_prog.wr(24'h30000B, 8'h00);
    rchk(24'h30000B, 8'h20);
    u_prog.wr(24'h300008, 8'hFA);
    u_prog.wr(24'h300008, 8'h0F);
    rchk(24'h300008, 8'h0A);
    u_prog.wr(24'h30000A, 8'h0E);
    u_prog.wr(24'h30000C, 8'h0B);
    acc(24'h001000, 24'h0, 3'b100, 2'b00);
    acc(24'h002000, 24'h0, 3'b100, 2'b11);
    acc(24'h004100, 24'h000900, 3'b010, 2'b01);
    acc(24'h004100, 24'h004200, 3'b010, 2'b11);
    acc(24'h000100, 24'h0, 3'b100, 2'b10);
    acc(24'h000010, 24'h0, 3'b101, 2'b10);
  endtask : t_user
  task automatic t_burn;
    u_prog.burn(24'h300003, 8'hE6);
    u_prog.burn(24'h300005, 8'h04);
    u_prog.burn(24'h300006, 8'h40);
    rchk(24'h300003, 8'h06);
    chk("divide_held", ctrl.watchdog_divide, 16'h8000);
    @(posedge clk_sys_i);
    reset_n_i <= 1'b0;
    repeat (3) @(posedge clk_sys_i);
    reset_n_i <= 1'b1;
    // Shared pin goes high so the plain input must show a one.
    pin <= 1'b1;
    repeat (4) @(posedge clk_sys_i);
    #1;
    chk("divide", ctrl.watchdog_divide, 16'h0008);
    chk("modes", {10'h0, ctrl.watchdog_run, ctrl.low_power_timer_osc, ctrl.extended_isa_on,
      ctrl.dedicated_debug_port, 2'b00}, 16'h0018);
    chk("prog_pins", {8'h0, sr, lok, pb3, ext_rst_n, pe3, dbg, 2'b00}, 16'h003C);
    chk("analog", {8'h00, acfg}, 16'h0007);
  endtask : t_burn
  task automatic t_lock;
    u_prog.burn(24'h30000B, 8'h00);
    rchk(24'h30000B, 8'h00);
    u_prog.wr(24'h300008, 8'h00);
    rchk(24'h300008, 8'h0A);
  endtask : t_lock
  task automatic tally_and_finish;
    if (n_fail == 0 && tests_run > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : tally_and_finish
  // The run needs about seventy cycles; the ceiling only catches a hang.
  always @(posedge clk_sys_i) begin
    cycles++;
    if (cycles == 3000) begin
      n_fail++;
      tally_and_finish();
    end
  end
  initial begin
    repeat (3) @(posedge clk_sys_i);
    reset_n_i <= 1'b1;
    repeat (2) @(posedge clk_sys_i);
    t_blank();
    t_user();
    t_burn();
    t_lock();
    tally_and_finish();
  end
endmodule : tb
`default_nettype wire
